// >>> src/sbpc_defines.svh
// timing and reset constants of the burst and protection control block
`ifndef SBPC_DEFINES_SVH
`define SBPC_DEFINES_SVH

// ****************************************************************
// clock
// ****************************************************************
`define SBPC_CLK_PERIOD_NS 25

// ****************************************************************
// blanking times, in their own units
// ****************************************************************
`define SBPC_T_BURST_MS 20
`define SBPC_T_OVERLOAD_MS 40
`define SBPC_T_LATCH_US 210
`define SBPC_T_BROWNOUT_US 270
`define SBPC_T_FAST_RESET_US 450

// ****************************************************************
// reset values
// ****************************************************************
`define SBPC_BROWNOUT_RST 1'b1
`define SBPC_EVEN_RST 1'b1

`endif

// >>> src/sbpc_pkg.sv
// types shared by the burst and protection control block
`default_nettype none
package sbpc_pkg;

    // protection mode of the controller
    typedef enum logic [2:0] {
        SBPC_NORMAL = 3'b000,
        SBPC_ODD_SKIP = 3'b001,
        SBPC_NORMAL_RESTART = 3'b010,
        SBPC_NON_SWITCH = 3'b011,
        SBPC_LATCH = 3'b100
    } sbpc_mode_t;

    // digitized comparator decisions, all active high
    typedef struct packed {
        logic fbb_below_entry;    // below burst_entry_threshold
        logic fbb_above_wake;     // burst_wake_comparator, 3.5V
        logic fbb_below_sleep;    // burst_sleep_comparator, 3.2V
        logic fbb_above_exit;     // burst_exit_comparator, 4.0V
        logic fbb_above_overload; // overload_comparator, 4.5V
        logic brl_below_latch;    // 0.4V
        logic brl_below_brownout; // 1V
        logic brl_above_recover;  // 1.25V
        logic vcc_above_ovp;      // supply_overvoltage_trip, 25.5V
        logic vcc_below_off;      // 10.5V
        logic vcc_above_on;       // 17V
        logic vcc_above_ref;      // 8V
        logic temp_above_trip;    // 130 C
        logic temp_below_recover; // 80 C
    } sbpc_cmp_t;

endpackage
`default_nettype wire

// >>> src/sbpc_sync.sv
// two-flop synchroniser for a bundle of comparator levels
`default_nettype none
module sbpc_sync #(
    parameter int unsigned W = 1
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> src/sbpc_blank_timer.sv
// blanking counter: done once run has held for CYCLES clocks
`default_nettype none
module sbpc_blank_timer #(
    parameter int unsigned CYCLES = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic run,
    output logic done
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LIM = W'(CYCLES);

    logic [W-1:0] cnt_q;

    // restarts whenever run drops, saturates at the limit
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (cnt_q != LIM) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign done = run && (cnt_q == LIM);
endmodule
`default_nettype wire

// >>> src/sbpc_control.sv
// burst mode, auto restart, latch and brownout control of the controller
`include "sbpc_defines.svh"
`default_nettype none
module sbpc_control
    import sbpc_pkg::*;
#(
    parameter int unsigned BURST_CYC =
        (`SBPC_T_BURST_MS * 1000000 + `SBPC_CLK_PERIOD_NS - 1) /
        `SBPC_CLK_PERIOD_NS,
    parameter int unsigned OVERLOAD_CYC =
        (`SBPC_T_OVERLOAD_MS * 1000000 + `SBPC_CLK_PERIOD_NS - 1) /
        `SBPC_CLK_PERIOD_NS,
    parameter int unsigned LATCH_CYC =
        (`SBPC_T_LATCH_US * 1000 + `SBPC_CLK_PERIOD_NS - 1) /
        `SBPC_CLK_PERIOD_NS,
    parameter int unsigned BROWNOUT_CYC =
        (`SBPC_T_BROWNOUT_US * 1000 + `SBPC_CLK_PERIOD_NS - 1) /
        `SBPC_CLK_PERIOD_NS,
    parameter int unsigned FAST_RESET_CYC =
        (`SBPC_T_FAST_RESET_US * 1000 + `SBPC_CLK_PERIOD_NS - 1) /
        `SBPC_CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire sbpc_cmp_t cmp_async,
    output logic switch_enable,
    output logic bias_enable,
    output logic burst_limit_select,
    output logic startup_cell_enable,
    output logic burst_flag,
    output logic brownout_active,
    output logic latch_active,
    output logic restart_even,
    output sbpc_mode_t protect_mode
);

    // ****************************************************************
    // input synchronisation
    // ****************************************************************
    sbpc_cmp_t c;

    // every comparator crosses two flops before use
    sbpc_sync #(
        .W($bits(sbpc_cmp_t))
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(cmp_async),
        .sync_out(c)
    );

    // ****************************************************************
    // state
    // ****************************************************************
    sbpc_mode_t mode_q;
    sbpc_mode_t mode_d;
    logic on_q;
    logic on_d;
    logic even_q;
    logic even_d;
    logic burst_q;
    logic burst_d;
    logic wake_q;
    logic wake_d;
    logic brown_q;
    logic brown_d;
    logic otp_q;
    logic otp_d;
    logic hold_q;
    logic hold_d;
    logic arm_q;
    logic arm_d;

    // ****************************************************************
    // supply sequencing
    // ****************************************************************
    wire on_rise = c.vcc_above_on && !on_q && !c.vcc_below_off;
    wire on_fall = on_q && c.vcc_below_off;
    wire ref_good = c.vcc_above_ref;

    // undervoltage turns the core off, 17V brings it back
    assign on_d = c.vcc_below_off ? 1'b0 :
                  (c.vcc_above_on ? 1'b1 : on_q);

    // ****************************************************************
    // mode decoding
    // ****************************************************************
    wire in_normal = (mode_q == SBPC_NORMAL);
    wire in_odd_skip = (mode_q == SBPC_ODD_SKIP);
    wire in_nrm_rst = (mode_q == SBPC_NORMAL_RESTART);
    wire in_non_sw = (mode_q == SBPC_NON_SWITCH);
    wire in_latch = (mode_q == SBPC_LATCH);

    // fault detection is blind on odd restart cycles
    wire det_en = in_normal || in_nrm_rst ||
                  ((in_odd_skip || in_non_sw) && even_q);

    // modes in which the gate may be driven
    wire mode_sw = in_normal || in_nrm_rst ||
                   (in_odd_skip && even_q);

    // burst gating: only while the bias is awake
    wire burst_ok = !burst_q || wake_q;

    wire sw_allow = on_q && !brown_q && !hold_q &&
                    mode_sw && burst_ok;

    // ****************************************************************
    // blanking timers
    // ****************************************************************
    logic burst_done;
    logic ovl_done;
    logic latch_done;
    logic brown_done;
    logic fast_done;

    wire burst_run = c.fbb_below_entry && on_q && in_normal &&
                     !burst_q && !brown_q;
    wire ovl_run = c.fbb_above_overload && on_q && det_en &&
                   mode_sw && !burst_q;
    wire latch_run = c.brl_below_latch && ref_good && !in_latch;
    wire brown_run = c.brl_below_brownout && !brown_q;
    // keeps running in the cycle that passes 1V so done meets rise_end
    wire fast_run = arm_q && !c.brl_below_latch;

    // 20ms light-load qualification before burst entry
    sbpc_blank_timer #(
        .CYCLES(BURST_CYC)
    ) u_burst_tmr (
        .ref_clk(ref_clk),
        .reset(reset),
        .run(burst_run),
        .done(burst_done)
    );

    // 40ms overload or open-loop qualification
    sbpc_blank_timer #(
        .CYCLES(OVERLOAD_CYC)
    ) u_ovl_tmr (
        .ref_clk(ref_clk),
        .reset(reset),
        .run(ovl_run),
        .done(ovl_done)
    );

    // 210us external latch request qualification
    sbpc_blank_timer #(
        .CYCLES(LATCH_CYC)
    ) u_latch_tmr (
        .ref_clk(ref_clk),
        .reset(reset),
        .run(latch_run),
        .done(latch_done)
    );

    // 270us brownout qualification
    sbpc_blank_timer #(
        .CYCLES(BROWNOUT_CYC)
    ) u_brown_tmr (
        .ref_clk(ref_clk),
        .reset(reset),
        .run(brown_run),
        .done(brown_done)
    );

    // measures the 0.4V to 1V rise time of the latch input
    sbpc_blank_timer #(
        .CYCLES(FAST_RESET_CYC)
    ) u_fast_tmr (
        .ref_clk(ref_clk),
        .reset(reset),
        .run(fast_run),
        .done(fast_done)
    );

    // ****************************************************************
    // fault events
    // ****************************************************************
    wire ovp_fault = det_en && c.vcc_above_ovp;
    wire otp_fault = det_en && c.temp_above_trip;
    wire odd_fault = ovp_fault || ovl_done;

    // rise window ends when the input passes 1V
    wire rise_end = arm_q && !c.brl_below_brownout;
    wire fast_clr = rise_end && fast_done;

    // a restart cycle that is about to become even
    wire to_even = on_rise && !even_q;

    // ****************************************************************
    // mode sequencing
    // ****************************************************************
    // latch request outranks everything except the 8V clear
    always_comb begin
        mode_d = mode_q;
        if (!ref_good) begin
            mode_d = SBPC_NORMAL;
        end else if (latch_done) begin
            mode_d = SBPC_LATCH;
        end else begin
            case (mode_q)
                SBPC_NORMAL: begin
                    if (otp_fault) begin
                        mode_d = SBPC_NON_SWITCH;
                    end else if (odd_fault) begin
                        mode_d = SBPC_ODD_SKIP;
                    end else if (on_fall) begin
                        mode_d = SBPC_NORMAL_RESTART;
                    end
                end
                SBPC_ODD_SKIP: begin
                    if (to_even && !c.vcc_above_ovp) begin
                        mode_d = SBPC_NORMAL;
                    end
                end
                SBPC_NORMAL_RESTART: begin
                    if (on_rise) begin
                        mode_d = SBPC_NORMAL;
                    end
                end
                SBPC_NON_SWITCH: begin
                    if (to_even && !otp_q) begin
                        mode_d = SBPC_NORMAL;
                    end
                end
                SBPC_LATCH: begin
                    if (fast_clr) begin
                        mode_d = SBPC_NORMAL;
                    end
                end
                default: begin
                    mode_d = SBPC_NORMAL;
                end
            endcase
        end
    end

    // parity restarts at zero on entry, flips on each new cycle
    assign even_d = (mode_d != mode_q) ? `SBPC_EVEN_RST :
                    (on_rise ? !even_q : even_q);

    // a fault seen on an even cycle stops switching until next cycle
    assign hold_d = (mode_d != mode_q || on_rise) ? 1'b0 :
                    ((in_odd_skip && odd_fault) ? 1'b1 : hold_q);

    // temperature hysteresis, trip at 130C, release 50C lower
    assign otp_d = c.temp_above_trip ? 1'b1 :
                   (c.temp_below_recover ? 1'b0 : otp_q);

    // ****************************************************************
    // burst mode
    // ****************************************************************
    // set wins; leaving normal mode or power also drops burst
    assign burst_d = burst_done ? 1'b1 :
                     ((c.fbb_above_exit || !on_q || !in_normal) ?
                      1'b0 : burst_q);

    // bias sleeps on entry and toggles on the 3.5V/3.2V hysteresis
    assign wake_d = (burst_done || !burst_q) ? 1'b0 :
                    (c.fbb_above_wake ? 1'b1 :
                     (c.fbb_below_sleep ? 1'b0 : wake_q));

    // ****************************************************************
    // brownout and fast reset arming
    // ****************************************************************
    // set wins: power-up and 270us low both hold brownout on
    assign brown_d = (!ref_good || brown_done) ? 1'b1 :
                     ((c.brl_above_recover && c.vcc_above_on) ?
                      1'b0 : brown_q);

    // armed by a pull below 0.4V, spent once the input passes 1V
    assign arm_d = c.brl_below_latch ? 1'b1 :
                   (rise_end ? 1'b0 : arm_q);

    // ****************************************************************
    // state registers
    // ****************************************************************
    // control state
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_q <= SBPC_NORMAL;
            on_q <= 1'b0;
            even_q <= `SBPC_EVEN_RST;
            hold_q <= 1'b0;
            otp_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            on_q <= on_d;
            even_q <= even_d;
            hold_q <= hold_d;
            otp_q <= otp_d;
        end
    end

    // burst, brownout and fast reset state
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            burst_q <= 1'b0;
            wake_q <= 1'b0;
            brown_q <= `SBPC_BROWNOUT_RST;
            arm_q <= 1'b0;
        end else begin
            burst_q <= burst_d;
            wake_q <= wake_d;
            brown_q <= brown_d;
            arm_q <= arm_d;
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    // one cycle behind the state, so every output is a flop
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            switch_enable <= 1'b0;
            bias_enable <= 1'b0;
            burst_limit_select <= 1'b0;
            startup_cell_enable <= 1'b1;
        end else begin
            switch_enable <= sw_allow;
            bias_enable <= on_q && burst_ok;
            burst_limit_select <= burst_q;
            startup_cell_enable <= !on_q;
        end
    end

    // status mirrors for the rest of the controller
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            burst_flag <= 1'b0;
            brownout_active <= `SBPC_BROWNOUT_RST;
            latch_active <= 1'b0;
            restart_even <= `SBPC_EVEN_RST;
            protect_mode <= SBPC_NORMAL;
        end else begin
            burst_flag <= burst_q;
            brownout_active <= brown_q;
            latch_active <= in_latch;
            restart_even <= even_q;
            protect_mode <= mode_q;
        end
    end

endmodule
`default_nettype wire

// >>> bench/sbpc_power_stage.sv
// power stage and sensing network model: analog levels to comparator levels
`default_nettype none
module sbpc_power_stage
    import sbpc_pkg::*;
#(
    parameter logic [9:0] ENTRY_CV = 10'h0A1
) (
    input wire logic ref_clk,
    input wire logic [9:0] vcc_dv,
    input wire logic [9:0] fbb_cv,
    input wire logic [9:0] brl_cv,
    input wire logic [9:0] temp_c,
    output sbpc_cmp_t cmp_async
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // comparators
    // ****************************************************************
    // vcc in 100mV, fbb and brl in 10mV, temperature in degrees
    always_ff @(posedge ref_clk) begin
        cmp_async.fbb_below_entry <= fbb_cv < ENTRY_CV;
        cmp_async.fbb_above_wake <= fbb_cv > 10'h15E;
        cmp_async.fbb_below_sleep <= fbb_cv <= 10'h140;
        cmp_async.fbb_above_exit <= fbb_cv > 10'h190;
        cmp_async.fbb_above_overload <= fbb_cv > 10'h1C2;
        cmp_async.brl_below_latch <= brl_cv < 10'h028;
        cmp_async.brl_below_brownout <= brl_cv < 10'h064;
        cmp_async.brl_above_recover <= brl_cv > 10'h07D;
        cmp_async.vcc_above_ovp <= vcc_dv > 10'h0FF;
        cmp_async.vcc_below_off <= vcc_dv < 10'h069;
        cmp_async.vcc_above_on <= vcc_dv >= 10'h0AA;
        cmp_async.vcc_above_ref <= vcc_dv > 10'h050;
        cmp_async.temp_above_trip <= temp_c > 10'h082;
        cmp_async.temp_below_recover <= temp_c < 10'h050;
    end
endmodule
`default_nettype wire

// >>> bench/sbpc_control_sva.sv
// assertions on the ports of the burst and protection control block
`default_nettype none
module sbpc_control_sva
    import sbpc_pkg::*;
#(
    parameter int unsigned BURST_CYC = 40,
    parameter int unsigned LATCH_CYC = 10
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire sbpc_cmp_t cmp_async,
    input wire logic switch_enable,
    input wire logic bias_enable,
    input wire logic burst_limit_select,
    input wire logic startup_cell_enable,
    input wire logic burst_flag,
    input wire logic brownout_active,
    input wire logic latch_active,
    input wire logic restart_even,
    input wire sbpc_mode_t protect_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [31:0] ent_q;
    logic [31:0] lat_q;
    // raw run lengths; the design sees them some edges late via its sync
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ent_q <= 32'h0;
            lat_q <= 32'h0;
        end else begin
            ent_q <= cmp_async.fbb_below_entry ? ent_q + 32'h1 : 32'h0;
            lat_q <= cmp_async.brl_below_latch ? lat_q + 32'h1 : 32'h0;
        end
    end
    latch_gate_off_a: assert property
        (latch_active[*3] |-> !switch_enable)
        else $error("switching while latched");
    brownout_gate_off_a: assert property
        (brownout_active[*3] |-> !switch_enable)
        else $error("switching in brownout");
    nonswitch_quiet_a: assert property
        ((protect_mode == SBPC_NON_SWITCH)[*3] |-> !switch_enable)
        else $error("switching in non-switch restart");
    odd_cycle_quiet_a: assert property
        ((protect_mode == SBPC_ODD_SKIP && !restart_even)[*3] |->
         !switch_enable)
        else $error("switching on odd restart cycle");
    burst_limit_a: assert property
        (burst_flag[*3] |-> burst_limit_select)
        else $error("burst without reduced limit");
    startup_cell_a: assert property
        (cmp_async.vcc_below_off[*8] |-> startup_cell_enable)
        else $error("start-up cell off at low supply");
    burst_wake_a: assert property
        ((burst_flag && cmp_async.fbb_above_wake && !latch_active &&
          !brownout_active && protect_mode == SBPC_NORMAL)[*6] |-> bias_enable)
        else $error("bias not restored in burst");
    burst_sleep_a: assert property
        ((burst_flag && cmp_async.fbb_below_sleep)[*6] |-> !bias_enable)
        else $error("bias left on in burst");
    entry_blank_a: assert property ($rose(burst_flag) |->
        $past(ent_q, 3) >= BURST_CYC || $past(ent_q, 4) >= BURST_CYC)
        else $error("burst entered before blanking ran out");
    latch_blank_a: assert property ($rose(latch_active) |->
        $past(lat_q, 3) >= LATCH_CYC || $past(lat_q, 4) >= LATCH_CYC)
        else $error("latch entered before blanking ran out");
    // every protection mode starts counting on an even cycle
    parity_entry_a: assert property
        ($changed(protect_mode) && protect_mode != SBPC_NORMAL |->
         restart_even)
        else $error("restart parity not even on mode entry");
    cover property ($rose(burst_flag));
    cover property ($rose(latch_active));
    cover property (protect_mode == SBPC_NON_SWITCH && restart_even);
endmodule
bind sbpc_control sbpc_control_sva #(
    .BURST_CYC(BURST_CYC),
    .LATCH_CYC(LATCH_CYC)
) sbpc_control_sva_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .cmp_async(cmp_async),
    .switch_enable(switch_enable),
    .bias_enable(bias_enable),
    .burst_limit_select(burst_limit_select),
    .startup_cell_enable(startup_cell_enable),
    .burst_flag(burst_flag),
    .brownout_active(brownout_active),
    .latch_active(latch_active),
    .restart_even(restart_even),
    .protect_mode(protect_mode)
);
`default_nettype wire

// >>> bench/test_smps_burst_protection_control.sv
// self-checking bench of the burst and protection control block
`default_nettype none
module test_smps_burst_protection_control
    import sbpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // short blanking counts keep the run brief
    localparam int BC = 40;
    localparam int OC = 80;
    localparam int LC = 10;
    localparam int BOC = 14;
    localparam int FC = 22;
    localparam int V = 0;
    localparam int F = 1;
    localparam int B = 2;
    localparam int T = 3;
    localparam logic [6:0] SW = 7'h40;
    localparam logic [6:0] BI = 7'h20;
    localparam logic [6:0] LIM = 7'h10;
    localparam logic [6:0] ST = 7'h08;
    localparam logic [6:0] BU = 7'h04;
    localparam logic [6:0] BO = 7'h02;
    localparam logic [6:0] LA = 7'h01;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] vcc_dv = 10'h03C;
    logic [9:0] fbb_cv = 10'h0FA;
    logic [9:0] brl_cv = 10'h0C8;
    logic [9:0] temp_c = 10'h019;
    sbpc_cmp_t cmp_async;
    logic switch_enable, bias_enable, burst_limit_select, startup_cell_enable;
    logic burst_flag, brownout_active, latch_active, restart_even;
    sbpc_mode_t protect_mode;
    wire logic [9:0] obs;
    logic [19:0] notes[$];
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 95691;
    event probe;
    assign obs = {protect_mode, switch_enable, bias_enable, burst_limit_select,
        startup_cell_enable, burst_flag, brownout_active, latch_active};
    sbpc_power_stage sbpc_power_stage_i (
        .ref_clk(ref_clk),
        .vcc_dv(vcc_dv),
        .fbb_cv(fbb_cv),
        .brl_cv(brl_cv),
        .temp_c(temp_c),
        .cmp_async(cmp_async)
    );
    sbpc_control #(
        .BURST_CYC(BC),
        .OVERLOAD_CYC(OC),
        .LATCH_CYC(LC),
        .BROWNOUT_CYC(BOC),
        .FAST_RESET_CYC(FC)
    ) sbpc_control_i (
        .ref_clk(ref_clk),
        .reset(reset),
        .cmp_async(cmp_async),
        .switch_enable(switch_enable),
        .bias_enable(bias_enable),
        .burst_limit_select(burst_limit_select),
        .startup_cell_enable(startup_cell_enable),
        .burst_flag(burst_flag),
        .brownout_active(brownout_active),
        .latch_active(latch_active),
        .restart_even(restart_even),
        .protect_mode(protect_mode)
    );
    // ****************************************************************
    // helpers
    // ****************************************************************
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [9:0] seen,
                         input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one level changes just after an edge, then n cycles pass
    task automatic put(input int k, input logic [9:0] x, input int n);
        @(posedge ref_clk);
        case (k)
            V: vcc_dv <= x;
            F: fbb_cv <= x;
            B: brl_cv <= x;
            default: temp_c <= x;
        endcase
        repeat (n) @(posedge ref_clk);
    endtask
    // note the expectation, then let the watcher judge it off the edge
    task automatic want(input logic cm, input logic [6:0] m,
                        input sbpc_mode_t md, input logic [6:0] b);
        notes.push_back({{3{cm}}, m, md & {3{cm}}, b});
        @(negedge ref_clk);
        ->probe;
    endtask
    task automatic cycle_vcc();
        put(V, 10'h064, 8);
        want(1'b0, ST, SBPC_NORMAL, ST);
        put(V, 10'h0B4, 8);
    endtask
    // watcher: the oldest note against the settled outputs
    always @(probe) begin
        logic [19:0] n;
        n = notes.pop_front();
        check("outputs", obs & n[19:10], n[9:0]);
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            wrap_up();
        end
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        put(V, 10'h078, 8);
        want(1'b1, BO | ST | SW, SBPC_NORMAL, BO | ST);
        put(V, 10'h0B4, 8);
        want(1'b1, BO | ST | SW, SBPC_NORMAL, SW);
        put(F, 10'h032 + 10'($unsigned($random(seed)) % 100),
            2 + $unsigned($random(seed)) % (BC - 8));
        put(F, 10'h0FA, 8);
        want(1'b0, BU, SBPC_NORMAL, 7'h00);
        put(F, 10'h064, BC + 8);
        want(1'b0, BU | LIM | BI | SW, SBPC_NORMAL, BU | LIM);
        put(F, 10'h168, 8);
        want(1'b0, BU | LIM | BI | SW, SBPC_NORMAL,
             BU | LIM | BI | SW);
        put(F, 10'h12C, 8);
        want(1'b0, LIM | BI | SW, SBPC_NORMAL, LIM);
        put(F, 10'h1A4, 8);
        want(1'b0, BU | LIM, SBPC_NORMAL, 7'h00);
        put(F, 10'h0FA, 8);
        // supply overvoltage clears only on an even restart cycle
        put(V, 10'h104, 8);
        want(1'b1, 7'h00, SBPC_ODD_SKIP, 7'h00);
        put(V, 10'h0B4, 8);
        want(1'b1, 7'h00, SBPC_ODD_SKIP, 7'h00);
        cycle_vcc();
        want(1'b1, SW, SBPC_ODD_SKIP, 7'h00);
        cycle_vcc();
        want(1'b1, SW, SBPC_NORMAL, SW);
        put(F, 10'h1D6, OC + 10);
        want(1'b1, 7'h00, SBPC_ODD_SKIP, 7'h00);
        put(F, 10'h0FA, 2);
        cycle_vcc();
        cycle_vcc();
        want(1'b1, SW, SBPC_NORMAL, SW);
        put(V, 10'h064, 8);
        want(1'b1, ST | SW, SBPC_NORMAL_RESTART, ST);
        put(V, 10'h0B4, 8);
        want(1'b1, ST | SW, SBPC_NORMAL, SW);
        // overtemperature needs the full hysteresis before recovery
        put(T, 10'h087, 8);
        want(1'b1, SW, SBPC_NON_SWITCH, 7'h00);
        put(T, 10'h064, 2);
        cycle_vcc();
        cycle_vcc();
        want(1'b1, SW, SBPC_NON_SWITCH, 7'h00);
        put(T, 10'h046, 2);
        cycle_vcc();
        cycle_vcc();
        want(1'b1, SW, SBPC_NORMAL, SW);
        // latch, quick rise keeps it, slow rise clears it
        put(B, 10'h01E, LC + 3);
        put(B, 10'h0C8, 8);
        want(1'b1, LA | SW, SBPC_LATCH, LA);
        put(B, 10'h01E, 3);
        put(B, 10'h03C, 5);
        put(B, 10'h0C8, 8);
        want(1'b0, LA, SBPC_NORMAL, LA);
        put(B, 10'h01E, 3);
        put(B, 10'h03C, FC + 4);
        want(1'b0, BO | SW, SBPC_NORMAL, BO);
        put(B, 10'h0C8, 8);
        want(1'b1, LA | BO | SW, SBPC_NORMAL, SW);
        put(B, 10'h01E, LC + 3);
        put(B, 10'h0C8, 8);
        want(1'b0, LA, SBPC_NORMAL, LA);
        put(V, 10'h03C, 8);
        want(1'b1, LA | BO, SBPC_NORMAL, BO);
        put(V, 10'h0B4, 8);
        want(1'b1, LA | BO | SW, SBPC_NORMAL, SW);
        put(B, 10'h03C, BOC - 4);
        put(B, 10'h0C8, 8);
        want(1'b0, BO, SBPC_NORMAL, 7'h00);
        @(posedge ref_clk);
        wrap_up();
    end
endmodule
`default_nettype wire
